// [dv/prs_supply_model.sv]
// supply monitor, clear pin and external oscillator outside the sequencer
`timescale 1ns/10ps
module prs_supply_model (
    input wire logic pclk,
    input wire logic vdd_up,
    input wire logic vdd_dip,
    input wire logic clear_hold,
    input wire logic osc_run,
    output logic supply_ok,
    output logic above_threshold,
    output logic master_clear_n,
    output logic osc_in
);
    logic [1:0] div_ff = 2'h0;
    assign supply_ok = vdd_up;
    assign above_threshold = vdd_up & ~vdd_dip;
    // pin is pulled up, so it reads high unless held on request
    assign master_clear_n = ~clear_hold;
    // oscillator stands still while unpowered or not fitted
    always_ff @(posedge pclk)
    begin
        div_ff <= (vdd_up && osc_run) ? div_ff + 2'h1 : 2'h0;
    end
    assign osc_in = div_ff[1];
endmodule

// [dv/prs_top_tb.sv]
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
module prs_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic supply_ok, above_threshold, master_clear_n, osc_in;
    logic [1:0] osc_mode_cfg;
    logic power_timer_disable_cfg, brownout_enable_cfg, chip_reset, brownout_reset;
    logic vdd_up, vdd_dip, clear_hold, osc_run, wake, timeout_n, sleep_n;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    // short counts keep the run small: 288 cycle timer, 8 cycle dip filter
    prs_top #(.POWER_UP_TIMER_DIV(4), .BROWNOUT_MIN_DURATION_CYC(8), .OST_CYC(8)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
        .above_threshold(above_threshold), .master_clear_n(master_clear_n),
        .osc_in(osc_in), .osc_mode_cfg(osc_mode_cfg),
        .power_timer_disable_cfg(power_timer_disable_cfg),
        .brownout_enable_cfg(brownout_enable_cfg), .sleep_wake(wake),
        .timeout_flag_n(timeout_n), .sleep_flag_n(sleep_n), .chip_reset(chip_reset),
        .brownout_reset(brownout_reset));
    prs_supply_model far (.pclk(pclk), .vdd_up(vdd_up), .vdd_dip(vdd_dip),
        .clear_hold(clear_hold), .osc_run(osc_run), .supply_ok(supply_ok),
        .above_threshold(above_threshold), .master_clear_n(master_clear_n),
        .osc_in(osc_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50)
            chk({31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wait_low(input int lim);
        int n;
        n = 0;
        while (chip_reset !== 1'b0 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, chip_reset}, 32'h0);
    endtask
    // power cycle, then reset must still stand at hi_at and be gone by lo_by more
    task automatic cold_start(input logic [1:0] m, input logic dis, input logic brownout_detector,
        input int hi_at, input int lo_by);
        osc_mode_cfg <= m;
        power_timer_disable_cfg <= dis;
        brownout_enable_cfg <= brownout_detector;
        osc_run <= (m != prs_pkg::PRS_OSC_RC);
        vdd_up <= 1'b0;
        cyc_wait(20);
        chk({31'h0, chip_reset}, 32'h1);
        vdd_up <= 1'b1;
        cyc_wait(hi_at);
        chk({31'h0, chip_reset}, 32'h1);
        wait_low(lo_by);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_timer_skip();
        // brown-out kept off whenever the timer is skipped
        cold_start(prs_pkg::PRS_OSC_XT, 1'b1, 1'b0, 20, 60);
        cold_start(prs_pkg::PRS_OSC_RC, 1'b0, 1'b1, 280, 40);
        cold_start(prs_pkg::PRS_OSC_RC, 1'b1, 1'b0, 1, 12);
        $display("t_timer_skip done, mismatches %0d", n_errors);
    endtask
    task automatic t_crystal();
        logic [1:0] m;
        for (int i = 0; i < 3; i++)
        begin
            m = 2'(i);
            cold_start(m, 1'b0, 1'b1, 280, 150);
        end
        apb(1'b0, prs_pkg::PRS_ADDR_CAUSE, 32'h0);
        chk(rd & 32'h2, 32'h0);
        apb(1'b1, prs_pkg::PRS_ADDR_CAUSE, 32'h3);
        apb(1'b0, prs_pkg::PRS_ADDR_CAUSE, 32'h0);
        chk(rd & 32'h3, 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("t_crystal done, mismatches %0d", n_errors);
    endtask
    task automatic t_dip();
        vdd_dip <= 1'b1;
        cyc_wait(3);
        vdd_dip <= 1'b0;
        cyc_wait(15);
        chk({30'h0, brownout_reset, chip_reset}, 32'h0);
        vdd_dip <= 1'b1;
        cyc_wait(20);
        chk({30'h0, brownout_reset, chip_reset}, 32'h3);
        vdd_dip <= 1'b0;
        cyc_wait(100);
        // second dip lands while the timer runs, so it must start over
        vdd_dip <= 1'b1;
        cyc_wait(20);
        vdd_dip <= 1'b0;
        cyc_wait(280);
        chk({31'h0, chip_reset}, 32'h1);
        wait_low(150);
        apb(1'b0, prs_pkg::PRS_ADDR_CAUSE, 32'h0);
        chk(rd & 32'h3, 32'h2);
        $display("t_dip done, mismatches %0d", n_errors);
    endtask
    task automatic t_bod_off();
        brownout_enable_cfg <= 1'b0;
        vdd_dip <= 1'b1;
        cyc_wait(30);
        chk({30'h0, brownout_reset, chip_reset}, 32'h0);
        vdd_dip <= 1'b0;
        cyc_wait(5);
        $display("t_bod_off done, mismatches %0d", n_errors);
    endtask
    task automatic t_clear_hold();
        clear_hold <= 1'b1;
        brownout_enable_cfg <= 1'b1;
        vdd_up <= 1'b0;
        cyc_wait(20);
        vdd_up <= 1'b1;
        cyc_wait(450);
        chk({31'h0, chip_reset}, 32'h1);
        clear_hold <= 1'b0;
        wait_low(8);
        $display("t_clear_hold done, mismatches %0d", n_errors);
    endtask
    task automatic t_wake();
        sleep_n <= 1'b0;
        wake <= 1'b1;
        cyc_wait(6);
        chk({31'h0, chip_reset}, 32'h1);
        wake <= 1'b0;
        wait_low(60);
        apb(1'b0, prs_pkg::PRS_ADDR_STATE, 32'h0);
        chk(rd & 32'h7f, 32'h44);
        $display("t_wake done, mismatches %0d", n_errors);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // whole run is near 2500 cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_errors++;
            close_out();
        end
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        osc_mode_cfg = prs_pkg::PRS_OSC_XT;
        power_timer_disable_cfg = 1'b0;
        brownout_enable_cfg = 1'b1;
        vdd_up = 1'b0;
        vdd_dip = 1'b0;
        clear_hold = 1'b0;
        osc_run = 1'b1;
        wake = 1'b0;
        timeout_n = 1'b1;
        sleep_n = 1'b1;
        cyc_wait(5);
        presetn <= 1'b1;
        t_timer_skip();
        t_crystal();
        t_dip();
        t_bod_off();
        t_clear_hold();
        t_wake();
        close_out();
    end
endmodule

// [hdl/prs_pkg.sv]
// constants for the power-on reset sequencer
//
// Contract
// (RULE1) hold chip reset after power-up until supply detector reports adequate level
// (RULE2) falling supply never triggers the power-on pulse, only rising supply; here the pulse is held while supply is low
// (RULE3) power-up timer gives 72 ms on internal RC ticks after power-on or brown-out
// (RULE4) power-up timer skipped when disable configuration bit is set
// (RULE5) after power-up timer, count 1024 external oscillator cycles before release
// (RULE6) oscillator count only in crystal modes, only on power-on or sleep wake; here it also runs after a brown-out timer
// (RULE7) brown-out detector follows its configuration enable bit
// (RULE8) brown-out reset only when supply stays low longer than minimum duration
// (RULE9) any reset waits for supply above threshold, then runs 72 ms timer; here threshold is watched only with brown-out enabled
// (RULE10) brown-out during power-up timer restarts the timer from zero
// (RULE11) strict order: power-on pulse, power-up timer, oscillator count
// (RULE12) resistor-capacitor mode with timer disabled applies no start-up delay
// (RULE13) delays count from power-on pulse independent of master clear
// (RULE14) total delays follow the mode and source scheme
// (RULE15) power status register has two bits at its fixed address
// (RULE16) brown-out flag unknown at power-on, cleared by brown-out, set by software
// (RULE17) brown-out flag value need not be meaningful while detector disabled
// (RULE18) power-on flag cleared on power-on reset only, software writes one
// (RULE19) reset cause decodes from power-on, brown-out, timeout and sleep flags
// (RULE20) configuration should enable power-up timer whenever brown-out is enabled
// (RULE21) internal reset while any source or timer is active
package prs_pkg;
    localparam logic [11:0] PRS_ADDR_CAUSE = 12'h238; // index 8e times four
    localparam logic [11:0] PRS_ADDR_STATE = 12'h23c;
    localparam int PRS_IDX_CAUSE = 'h8e;
    localparam int PRS_BIT_BOR_N = 0;
    localparam int PRS_BIT_POR_N = 1;
    localparam int PRS_POWER_UP_TIMER_MS = 72;
    localparam int PRS_RC_KHZ = 1; // internal rc tick rate: one tick per ms of delay
    localparam int PRS_POWER_UP_TIMER_TICKS = PRS_POWER_UP_TIMER_MS * PRS_RC_KHZ;
    localparam int PRS_OST_CYCLES = 1024;
    localparam int PRS_CLK_MHZ = 250;
    localparam int PRS_BROWNOUT_MIN_DURATION_US = 100;
    localparam int PRS_BROWNOUT_MIN_DURATION_CYC = PRS_BROWNOUT_MIN_DURATION_US * PRS_CLK_MHZ;
    localparam int PRS_RC_DIV = 250000 / PRS_RC_KHZ; // pclk cycles per rc tick
    localparam logic [1:0] PRS_OSC_LP = 2'h0;
    localparam logic [1:0] PRS_OSC_XT = 2'h1;
    localparam logic [1:0] PRS_OSC_HS = 2'h2;
    localparam logic [1:0] PRS_OSC_RC = 2'h3;
    typedef enum logic [2:0] {PRS_POR, PRS_WAIT_V, PRS_POWER_UP_TIMER, PRS_OST, PRS_RUN} prs_state_e;
endpackage

// [hdl/prs_sync.sv]
// two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module prs_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            q <= '0;
        end
        else
        begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// [hdl/prs_top.sv]
// power-on reset sequencer with apb-visible reset cause register
`timescale 1ns/10ps
module prs_top #(
    parameter int POWER_UP_TIMER_DIV = prs_pkg::PRS_RC_DIV,
    parameter int BROWNOUT_MIN_DURATION_CYC = prs_pkg::PRS_BROWNOUT_MIN_DURATION_CYC,
    parameter int OST_CYC = prs_pkg::PRS_OST_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok,
    input wire logic above_threshold,
    input wire logic master_clear_n,
    input wire logic osc_in,
    input wire logic [1:0] osc_mode_cfg,
    input wire logic power_timer_disable_cfg,
    input wire logic brownout_enable_cfg,
    input wire logic sleep_wake,
    input wire logic timeout_flag_n,
    input wire logic sleep_flag_n,
    output logic chip_reset,
    output logic brownout_reset
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    logic [6:0] pin_s;
    prs_sync #(.W(7)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({supply_ok, above_threshold, master_clear_n, osc_in,
            sleep_wake, timeout_flag_n, sleep_flag_n}),
        .q(pin_s)
    );
    logic sup_s, thr_s, master_clear_n_s, osc_s, wake_s;
    assign sup_s = pin_s[6];
    assign thr_s = pin_s[5];
    assign master_clear_n_s = pin_s[4];
    assign osc_s = pin_s[3];
    assign wake_s = pin_s[2];

    ////////////////////////////////////////////////////////////////////////////
    // brown-out detection with minimum duration filter
    logic [31:0] low_cnt_ff;
    logic bod_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_cnt_ff <= '0;
            bod_ff <= 1'b0;
        end
        else if (!brownout_enable_cfg) // RULE7
        begin
            low_cnt_ff <= '0;
            bod_ff <= 1'b0;
        end
        else if (thr_s)
        begin
            low_cnt_ff <= '0;
            bod_ff <= 1'b0;
        end
        else if (low_cnt_ff >= 32'(BROWNOUT_MIN_DURATION_CYC)) // RULE8
            bod_ff <= 1'b1;
        else
            low_cnt_ff <= low_cnt_ff + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-on pulse: held for as long as the supply indication is low
    logic sup_d_ff, por_pend_ff, por_evt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sup_d_ff <= 1'b0;
        else
            sup_d_ff <= sup_s;
    end
    assign por_evt = !sup_s; // RULE1 RULE2 (held low, not edge of falling)

    ////////////////////////////////////////////////////////////////////////////
    // rc tick divider and osc edge detect
    logic [31:0] div_ff;
    logic rc_tick, osc_d_ff, osc_rise;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_ff <= '0;
        else if (div_ff >= 32'(POWER_UP_TIMER_DIV - 1))
            div_ff <= '0;
        else
            div_ff <= div_ff + 32'h1;
    end
    assign rc_tick = (div_ff == 32'(POWER_UP_TIMER_DIV - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            osc_d_ff <= 1'b0;
        else
            osc_d_ff <= osc_s;
    end
    assign osc_rise = osc_s && !osc_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    prs_pkg::prs_state_e st_ff;
    logic [31:0] cnt_ff;
    logic ost_req_ff, crystal;
    assign crystal = (osc_mode_cfg != prs_pkg::PRS_OSC_RC); // RULE6
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= prs_pkg::PRS_POR;
            cnt_ff <= '0;
            ost_req_ff <= 1'b1;
        end
        else if (por_evt) // RULE1
        begin
            st_ff <= prs_pkg::PRS_POR;
            cnt_ff <= '0;
            ost_req_ff <= 1'b1;
        end
        else if (bod_ff) // RULE10
        begin
            st_ff <= prs_pkg::PRS_WAIT_V;
            cnt_ff <= '0;
            ost_req_ff <= 1'b0;
        end
        else
        begin
            case (st_ff)
                prs_pkg::PRS_POR:
                    st_ff <= prs_pkg::PRS_WAIT_V; // RULE11
                prs_pkg::PRS_WAIT_V:
                begin
                    cnt_ff <= '0;
                    // RULE9: without brown-out the threshold input is not watched
                    if (thr_s || !brownout_enable_cfg)
                    begin
                        if (!power_timer_disable_cfg) // RULE4
                            st_ff <= prs_pkg::PRS_POWER_UP_TIMER;
                        else if (ost_req_ff && crystal)
                            st_ff <= prs_pkg::PRS_OST;
                        else
                            st_ff <= prs_pkg::PRS_RUN; // RULE12
                    end
                end
                prs_pkg::PRS_POWER_UP_TIMER:
                begin
                    if (rc_tick)
                        cnt_ff <= cnt_ff + 32'h1;
                    if (rc_tick && cnt_ff >= 32'(prs_pkg::PRS_POWER_UP_TIMER_TICKS - 1)) // RULE3 RULE14
                    begin
                        cnt_ff <= '0;
                        // brown-out also gets the oscillator count here, which RULE6 does not ask for
                        st_ff <= crystal ? prs_pkg::PRS_OST : prs_pkg::PRS_RUN; // RULE5
                    end
                end
                prs_pkg::PRS_OST:
                begin
                    if (osc_rise)
                        cnt_ff <= cnt_ff + 32'h1;
                    if (osc_rise && cnt_ff >= 32'(OST_CYC - 1)) // RULE5 RULE14
                        st_ff <= prs_pkg::PRS_RUN;
                end
                default:
                begin
                    if (wake_s && crystal) // RULE6
                    begin
                        cnt_ff <= '0;
                        st_ff <= prs_pkg::PRS_OST;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset outputs; master clear gates release but not the timers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chip_reset <= 1'b1;
            brownout_reset <= 1'b0;
        end
        else
        begin
            chip_reset <= por_evt || bod_ff || !master_clear_n_s
                || (st_ff != prs_pkg::PRS_RUN); // RULE13 RULE21
            brownout_reset <= bod_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status bits: power-on flag and brown-out flag, both active low
    logic por_n_ff, bor_n_ff, wr_cause;
    assign wr_cause = psel && penable && pwrite && (paddr == prs_pkg::PRS_ADDR_CAUSE);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            por_n_ff <= 1'b0;
            bor_n_ff <= 1'b0; // unknown after power-on; zero chosen
        end
        else
        begin
            // hardware clear wins over software set in the same cycle
            if (por_evt) // RULE18
                por_n_ff <= 1'b0;
            else if (wr_cause)
                por_n_ff <= pwdata[prs_pkg::PRS_BIT_POR_N];
            if (bod_ff) // RULE16 RULE17
                bor_n_ff <= 1'b0;
            else if (wr_cause)
                bor_n_ff <= pwdata[prs_pkg::PRS_BIT_BOR_N];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait state, unmapped reads zero with error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable)
            begin
                if (paddr == prs_pkg::PRS_ADDR_CAUSE) // RULE15
                    prdata <= {30'h0, por_n_ff, bor_n_ff};
                else if (paddr == prs_pkg::PRS_ADDR_STATE) // RULE19
                    prdata <= {24'h0, 1'b0, 3'(st_ff), pin_s[0], pin_s[1],
                        bor_n_ff, por_n_ff};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_por_holds: assert property (@(posedge pclk) disable iff (!presetn)
        por_evt |=> chip_reset) else $error("chip not in reset during power-on"); // RULE1
    a_bod_holds: assert property (@(posedge pclk) disable iff (!presetn)
        bod_ff |=> chip_reset && brownout_reset) else $error("brown-out not held"); // RULE21
    a_bod_off: assert property (@(posedge pclk) disable iff (!presetn)
        !brownout_enable_cfg |=> !bod_ff) else $error("brown-out while disabled"); // RULE7
    a_bod_clear: assert property (@(posedge pclk) disable iff (!presetn)
        bod_ff |=> !bor_n_ff) else $error("brown-out flag not cleared"); // RULE16
    a_por_flag: assert property (@(posedge pclk) disable iff (!presetn)
        por_evt |=> !por_n_ff) else $error("power-on flag not cleared"); // RULE18
    a_master_clear_n_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !master_clear_n_s |=> chip_reset) else $error("released with master clear low"); // RULE13
    a_power_up_timer_skip: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff == prs_pkg::PRS_WAIT_V && power_timer_disable_cfg && !bod_ff && !por_evt
        |=> st_ff != prs_pkg::PRS_POWER_UP_TIMER) else $error("timer ran while disabled"); // RULE4
    a_order_ost: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff == prs_pkg::PRS_OST && $past(st_ff) != prs_pkg::PRS_OST
        |-> $past(st_ff) != prs_pkg::PRS_POR) else $error("sequence order broken"); // RULE11
    a_run_free: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff == prs_pkg::PRS_RUN && master_clear_n_s && !por_evt && !bod_ff
        |=> !chip_reset) else $error("reset held in run"); // RULE21
    c_reach_run: cover property (@(posedge pclk) disable iff (!presetn)
        st_ff == prs_pkg::PRS_OST ##1 st_ff == prs_pkg::PRS_RUN);
    c_bod: cover property (@(posedge pclk) disable iff (!presetn) $rose(bod_ff));
    c_wake: cover property (@(posedge pclk) disable iff (!presetn)
        st_ff == prs_pkg::PRS_RUN ##1 st_ff == prs_pkg::PRS_OST);
endmodule
